/* File: verilog/cdf_defines.svh */
// constants for the can diagnostic flag latches
`ifndef CDF_DEFINES_SVH
`define CDF_DEFINES_SVH

// ----------------------------------------------------------------
// flag vector layout
// ----------------------------------------------------------------
`define CDF_NFLAGS 15
`define CDF_BIT_WAKE 0
`define CDF_BIT_OTEMP 1
`define CDF_BIT_RX_LOW 2
`define CDF_BIT_RX_HIGH 3
`define CDF_BIT_TX_DOM 4
`define CDF_BIT_BUS_DOM 5
`define CDF_BIT_OCUR 6
`define CDF_BIT_SUSPECT 7
`define CDF_BIT_CONFIRM 8
`define CDF_BIT_L_BAT 9
`define CDF_BIT_L_VDD 10
`define CDF_BIT_L_GND 11
`define CDF_BIT_H_BAT 12
`define CDF_BIT_H_VDD 13
`define CDF_BIT_H_GND 14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CDF_FLAGS_RST 15'h0000
`define CDF_STATE_RST 3'h0
// flags that clear on read alone, with no recovery condition
`define CDF_READ_ONLY_CLEAR 15'h0001

`endif

/* File: verilog/cdf_pkg.sv */
// types shared by the can diagnostic flag latches
package cdf_pkg;
	typedef logic [14:0] cdf_flags_t;
	typedef logic [2:0] cdf_rt_t;
endpackage

/* File: verilog/cdf_sync_if.sv */
// carrier between the pin synchroniser and the flag latches
`timescale 1ns/1ps
interface cdf_sync_if;
	logic [14:0] raw;
	logic [14:0] level;
	logic [14:0] rise;
	modport sync (input raw, output level, output rise);
	modport user (output raw, input level, input rise);
endinterface

/* File: verilog/cdf_sync.sv */
// three-stage synchroniser with agreement filter for detector levels
`timescale 1ns/1ps
`include "cdf_defines.svh"
module cdf_sync (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	cdf_sync_if.sync bus
);
	import cdf_pkg::*;

	typedef struct packed {
		cdf_flags_t s1;
		cdf_flags_t s2;
		cdf_flags_t s3;
		cdf_flags_t lvl;
		cdf_flags_t rise;
	} cdf_sync_s;

	cdf_sync_s st_q;
	cdf_sync_s st_d;

	// stage one feeds only stage two; level moves when stages two and three agree
	always_comb begin
		st_d = st_q;
		st_d.s1 = bus.raw;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.lvl = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 | st_q.s3));
		st_d.rise = st_d.lvl & ~st_q.lvl;
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.level = st_q.lvl;
	assign bus.rise = st_q.rise;
endmodule

/* File: verilog/cdf_flags.sv */
// can diagnostic flag latches with read-and-recover clearing
`timescale 1ns/1ps
`include "cdf_defines.svh"
module cdf_flags (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire cdf_pkg::cdf_flags_t i_det,
	input wire logic i_read,
	input wire cdf_pkg::cdf_rt_t i_rt_enable,
	output logic o_read_valid,
	output cdf_pkg::cdf_flags_t o_read_data,
	output cdf_pkg::cdf_flags_t o_flags,
	output cdf_pkg::cdf_flags_t o_pending_clear,
	output cdf_pkg::cdf_rt_t o_rt_state
);
	import cdf_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		cdf_flags_t flags;
		cdf_flags_t armed;
		cdf_flags_t rdata;
		logic rvalid;
		cdf_rt_t rt;
	} cdf_state_s;

	cdf_state_s st_q;
	cdf_state_s st_d;
	cdf_sync_if sif ();

	// ----------------------------------------------------------------
	// detector synchroniser
	// ----------------------------------------------------------------
	// detector inputs come from analogue comparators outside this clock
	// a level caught by fewer than two successive clock edges never reaches the flags
	// the wake edge detector starts from the idle low level after reset
	assign sif.raw = i_det;

	cdf_sync u_sync (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.bus(sif.sync)
	);

	// ----------------------------------------------------------------
	// detector views
	// ----------------------------------------------------------------
	// bit map of the flag word, as returned on a read
	// 0 bus wake event, cleared by the read alone
	// 1 interface overtemperature
	// 2 receive pin stuck low
	// 3 receive pin stuck at recessive
	// 4 transmit pin held dominant
	// 5 bus dominant past its timeout
	// 6 driver overcurrent
	// 7 bus fault suspected, type not yet known
	// 8 bus fault confirmed
	// 9 to 11 low wire short to battery, logic supply, ground
	// 12 to 14 high wire short to battery, logic supply, ground
	logic wake_edge;
	logic otemp_lvl;
	logic rx_low_lvl;
	logic rx_high_lvl;
	logic tx_dom_lvl;
	logic bus_dom_lvl;
	logic ocur_lvl;
	logic suspect_lvl;
	logic confirm_lvl;
	logic l_bat_lvl;
	logic l_vdd_lvl;
	logic l_gnd_lvl;
	logic h_bat_lvl;
	logic h_vdd_lvl;
	logic h_gnd_lvl;

	// wake is an event: only the first synced cycle of its level counts
	assign wake_edge = sif.rise[`CDF_BIT_WAKE];
	// rising edges of the fault levels are not used
	// thermal and current detectors are levels
	assign otemp_lvl = sif.level[`CDF_BIT_OTEMP];
	assign ocur_lvl = sif.level[`CDF_BIT_OCUR];
	// local pin faults on the receive and transmit lines
	assign rx_low_lvl = sif.level[`CDF_BIT_RX_LOW];
	assign rx_high_lvl = sif.level[`CDF_BIT_RX_HIGH];
	assign tx_dom_lvl = sif.level[`CDF_BIT_TX_DOM];
	// bus clamp and the two stages of bus fault detection
	assign bus_dom_lvl = sif.level[`CDF_BIT_BUS_DOM];
	assign suspect_lvl = sif.level[`CDF_BIT_SUSPECT];
	assign confirm_lvl = sif.level[`CDF_BIT_CONFIRM];
	// low wire shorts
	assign l_bat_lvl = sif.level[`CDF_BIT_L_BAT];
	assign l_vdd_lvl = sif.level[`CDF_BIT_L_VDD];
	assign l_gnd_lvl = sif.level[`CDF_BIT_L_GND];
	// high wire shorts
	assign h_bat_lvl = sif.level[`CDF_BIT_H_BAT];
	assign h_vdd_lvl = sif.level[`CDF_BIT_H_VDD];
	assign h_gnd_lvl = sif.level[`CDF_BIT_H_GND];

	// ----------------------------------------------------------------
	// flag update
	// ----------------------------------------------------------------
	// one flag drops once a read armed it; a fault flag also needs recovery
	// the read-only bit makes the level irrelevant
	function automatic logic release_bit(input logic armed, input logic level,
		input logic read_only);
		logic r;
		r = armed & (~level | read_only);
		return r;
	endfunction

	// a host that read during a fault need not read again after recovery
	// next flags, arm bits, snapshot and real-time state
	always_comb begin
		cdf_flags_t set_v;
		cdf_flags_t clr_v;
		cdf_flags_t arm_v;
		cdf_flags_t next_v;
		set_v = '0;
		clr_v = '0;
		arm_v = st_q.armed;
		next_v = '0;
		st_d = st_q;

		// set terms: the event edge for wake, the live level for faults
		set_v[`CDF_BIT_WAKE] = wake_edge;
		// thermal and current
		set_v[`CDF_BIT_OTEMP] = otemp_lvl;
		set_v[`CDF_BIT_OCUR] = ocur_lvl;
		// pin faults
		set_v[`CDF_BIT_RX_LOW] = rx_low_lvl;
		set_v[`CDF_BIT_RX_HIGH] = rx_high_lvl;
		set_v[`CDF_BIT_TX_DOM] = tx_dom_lvl;
		// bus clamp and fault detection stages
		set_v[`CDF_BIT_BUS_DOM] = bus_dom_lvl;
		set_v[`CDF_BIT_SUSPECT] = suspect_lvl;
		set_v[`CDF_BIT_CONFIRM] = confirm_lvl;
		// wire shorts
		set_v[`CDF_BIT_L_BAT] = l_bat_lvl;
		set_v[`CDF_BIT_L_VDD] = l_vdd_lvl;
		set_v[`CDF_BIT_L_GND] = l_gnd_lvl;
		set_v[`CDF_BIT_H_BAT] = h_bat_lvl;
		set_v[`CDF_BIT_H_VDD] = h_vdd_lvl;
		set_v[`CDF_BIT_H_GND] = h_gnd_lvl;

		// release terms: wake needs only the read, faults need recovery too
		clr_v[`CDF_BIT_WAKE] = release_bit(arm_v[`CDF_BIT_WAKE], 1'h0, 1'h1);
		// thermal and current
		clr_v[`CDF_BIT_OTEMP] = release_bit(arm_v[`CDF_BIT_OTEMP], otemp_lvl, 1'h0);
		clr_v[`CDF_BIT_OCUR] = release_bit(arm_v[`CDF_BIT_OCUR], ocur_lvl, 1'h0);
		// pin faults
		clr_v[`CDF_BIT_RX_LOW] = release_bit(arm_v[`CDF_BIT_RX_LOW], rx_low_lvl, 1'h0);
		clr_v[`CDF_BIT_RX_HIGH] = release_bit(arm_v[`CDF_BIT_RX_HIGH], rx_high_lvl, 1'h0);
		clr_v[`CDF_BIT_TX_DOM] = release_bit(arm_v[`CDF_BIT_TX_DOM], tx_dom_lvl, 1'h0);
		// bus clamp and fault detection stages
		clr_v[`CDF_BIT_BUS_DOM] = release_bit(arm_v[`CDF_BIT_BUS_DOM], bus_dom_lvl, 1'h0);
		clr_v[`CDF_BIT_SUSPECT] = release_bit(arm_v[`CDF_BIT_SUSPECT], suspect_lvl, 1'h0);
		clr_v[`CDF_BIT_CONFIRM] = release_bit(arm_v[`CDF_BIT_CONFIRM], confirm_lvl, 1'h0);
		// wire shorts
		clr_v[`CDF_BIT_L_BAT] = release_bit(arm_v[`CDF_BIT_L_BAT], l_bat_lvl, 1'h0);
		clr_v[`CDF_BIT_L_VDD] = release_bit(arm_v[`CDF_BIT_L_VDD], l_vdd_lvl, 1'h0);
		clr_v[`CDF_BIT_L_GND] = release_bit(arm_v[`CDF_BIT_L_GND], l_gnd_lvl, 1'h0);
		clr_v[`CDF_BIT_H_BAT] = release_bit(arm_v[`CDF_BIT_H_BAT], h_bat_lvl, 1'h0);
		clr_v[`CDF_BIT_H_VDD] = release_bit(arm_v[`CDF_BIT_H_VDD], h_vdd_lvl, 1'h0);
		clr_v[`CDF_BIT_H_GND] = release_bit(arm_v[`CDF_BIT_H_GND], h_gnd_lvl, 1'h0);

		// set wins, so an event in the release cycle keeps its flag
		next_v = (st_q.flags & ~clr_v) | set_v;
		st_d.flags = next_v;
		st_d.armed = arm_v & ~clr_v;

		// a read returns the word after this edge and arms only what it returned
		st_d.rvalid = i_read;
		if (i_read) begin
			st_d.rdata = next_v;
			st_d.armed = st_d.armed | next_v;
		end

		// real-time enables are registered unchanged; reads never touch them
		st_d.rt = i_rt_enable;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset clears flags, arm bits and snapshot alike
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// every output comes straight from a flip-flop
	// read handshake and snapshot
	assign o_read_valid = st_q.rvalid;
	assign o_read_data = st_q.rdata;
	// live latched flags and the ones waiting for recovery
	assign o_flags = st_q.flags;
	assign o_pending_clear = st_q.armed;
	// real-time state, one cycle behind its enables
	assign o_rt_state = st_q.rt;
endmodule

/* File: bench/cdf_flags_assertions.sv */
// flag latch checks
`timescale 1ns/1ps
module cdf_flags_chk (
	input logic i_clk_sys,
	input logic i_resetn,
	input logic [14:0] i_det,
	input logic i_read,
	input logic [2:0] i_rt_enable,
	input logic o_read_valid,
	input logic [14:0] o_read_data,
	input logic [14:0] o_flags,
	input logic [14:0] o_pending_clear,
	input logic [2:0] o_rt_state
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	property p_rv; i_read |=> o_read_valid; endproperty
	a_rv: assert property (p_rv) else $error("late");
	property p_hold; !i_read |=> $stable(o_read_data); endproperty
	a_hold: assert property (p_hold) else $error("moved");
	property p_rt; i_resetn |=> o_rt_state == $past(i_rt_enable); endproperty
	a_rt: assert property (p_rt) else $error("lag");
	property p_wake; (!i_det[0])[*6] ##0 o_read_valid && o_read_data[0] |=> !o_flags[0]; endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_set; i_det[6] [*8] |-> o_flags[6]; endproperty
	a_set: assert property (p_set) else $error("unset");
	property p_keep; o_flags[2] && !o_pending_clear[2] && !i_read |=> o_flags[2]; endproperty
	a_keep: assert property (p_keep) else $error("early");
	property p_arm; o_read_valid && o_read_data[5] && o_flags[5] |-> o_pending_clear[5]; endproperty
	a_arm: assert property (p_arm) else $error("unarmed");
	property p_rel; (!i_det[9])[*8] ##0 o_pending_clear[9] |=> !o_flags[9]; endproperty
	a_rel: assert property (p_rel) else $error("held");
	c_rd: cover property (o_read_valid);
	c_rel: cover property (o_pending_clear[9] ##1 !o_flags[9]);
	c_set: cover property (o_flags[14]);
endmodule
bind cdf_flags cdf_flags_chk u_chk (.i_clk_sys, .i_resetn, .i_det, .i_read, .i_rt_enable,
	.o_read_valid, .o_read_data, .o_flags, .o_pending_clear, .o_rt_state);

/* File: bench/cdf_host.sv */
// host model issuing read strobes
`timescale 1ns/1ps
module cdf_host (
	input logic i_clk,
	input logic i_go,
	output logic o_read = 1'b0
);
	always @(negedge i_clk) o_read <= i_go;
endmodule

/* File: bench/tb.sv */
// bench for the can flag latches
`timescale 1ns/1ps
module tb;
	logic clk = 0, rstn = 0, go = 0, rd, rv;
	logic [14:0] det = 0, dat, r, e, q[$];
	logic [14:0] fl, pc;
	logic [2:0] en = 3'h0, rt;
	int err_count = 0, tests_run = 0, seed = 89944;
	always #20 clk = ~clk;
	cdf_host u_h (.i_clk(clk), .i_go(go), .o_read(rd));
	cdf_flags DUT (.i_clk_sys(clk), .i_resetn(rstn), .i_det(det), .i_read(rd),
		.i_rt_enable(en), .o_read_valid(rv), .o_read_data(dat), .o_flags(fl),
		.o_pending_clear(pc), .o_rt_state(rt));
	task automatic rx(input logic [14:0] x);
		q.push_back(x);
		@(posedge clk) go = 1;
		@(posedge clk) go = 0;
		repeat (4) @(negedge clk);
	endtask
	task automatic report_and_stop();
		$display("run %0d bad %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(negedge clk) if (rv === 1'b1) begin
		e = q.pop_front();
		tests_run++;
		if (dat !== e) begin
			err_count++;
			$display("CHECK FAILED %0t %h %h", $time, dat, e);
		end
	end
	initial #60000 begin
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(negedge clk);
		rstn = 1;
		for (int i = 0; i < 6; i++) begin
			r = 15'($random(seed));
			det = r;
			en = 3'($random(seed));
			repeat (10) @(negedge clk);
			tests_run++;
			if (fl !== r) begin
				err_count++;
				$display("CHECK FAILED %0t %h %h", $time, fl, r);
			end
			if (i[0]) det = 0;
			repeat (10) @(negedge clk);
			rx(r);
			rx(i[0] ? 15'h0000 : r & 15'h7FFE);
			det = 0;
			repeat (10) @(negedge clk);
			rx(15'h0000);
			tests_run++;
			if ({rt, fl, pc} !== {en, 30'h0}) begin
				err_count++;
				$display("CHECK FAILED %0t %h %h", $time, {rt, fl, pc}, {en, 30'h0});
			end
			$display("test %0d done", i);
		end
		report_and_stop();
	end
endmodule
